// ---- verilog/ilm_regs.vh ----
// register offsets, field positions, reset values for the level and mask block
`ifndef ILM_REGS_VH
`define ILM_REGS_VH
`define ILM_ADDR_W          16
`define ILM_OFF_LEVEL7      16'hF62C
`define ILM_OFF_MASK        16'hF640
`define ILM_OFF_PENDING     16'hF680
`define ILM_LVL_W           3
`define ILM_POS_SRC31       24
`define ILM_POS_SRC30       16
`define ILM_POS_SRC15       8
`define ILM_POS_SRC14       0
`define ILM_POS_MASK        0
`define ILM_RST_LEVEL       3'h0
`define ILM_RST_MASK        3'h0
`define ILM_LVL_MAX         3'h7
`define ILM_SYNC_STAGES     2
`endif

// ---- verilog/ilm_sync.v ----
// two-flop synchroniser for the raw request lines
`timescale 1ns/1ps
module ilm_sync #(
  parameter W = 4
) (
  input  wire         core_clk,
  input  wire         nrst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule

// ---- verilog/ilm_arbiter.v ----
// picks the highest level among pending sources that beat the mask
`timescale 1ns/1ps
module ilm_arbiter #(
  parameter N = 4
) (
  input  wire [N-1:0]   pend,
  input  wire [3*N-1:0] levels,
  input  wire [2:0]     mask,
  output reg            req,
  output reg  [2:0]     best
);
  integer i;
  reg [2:0] lv;
  always @* begin
    req  = 1'b0;
    best = 3'h0;
    lv   = 3'h0;
    for (i = 0; i < N; i = i + 1) begin
      lv = levels[3*i +: 3];
      // level 0 never passes since mask >= 0; strict compare blocks equal levels
      if (pend[i] && (lv > mask) && (lv > best)) begin
        req  = 1'b1;
        best = lv;
      end
    end
  end
endmodule

// ---- verilog/ilm_top.v ----
// interrupt level and mask block: level fields, mask threshold, request out
// Operation
// - level field bits 26:24 of level register seven sets source 31 level
// - level field bits 18:16 of level register seven sets source 30 level
// - level field bits 10:8 of level register seven sets source 15 level
// - level field bits 2:0 of level register seven sets source 14 level
// - level value zero disables the source entirely
// - values one to seven are levels one to seven, seven highest
// - all four level fields reset to zero
// - mask threshold in bits 2:0 of mask register, upper bits reserved, reset zero
// - block levels equal to or below the mask, pass strictly higher
// - mask zero lets every enabled level through
// - mask seven blocks everything
// - pending status shows raw requests regardless of levels and mask
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "ilm_regs.vh"
module ilm_top (
  core_clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  irq_raw,
  cpu_irq,
  cpu_irq_level,
  src_enabled
);
  input                      core_clk;
  input                      nrst;
  input  [`ILM_ADDR_W-1:0]   reg_addr;
  input  [31:0]              reg_wdata;
  input                      reg_wr;
  input                      reg_rd;
  output [31:0]              reg_rdata;
  input  [3:0]               irq_raw;
  output                     cpu_irq;
  output [2:0]               cpu_irq_level;
  output [3:0]               src_enabled;

  wire                       core_clk;
  wire                       nrst;
  wire   [`ILM_ADDR_W-1:0]   reg_addr;
  wire   [31:0]              reg_wdata;
  wire                       reg_wr;
  wire                       reg_rd;
  reg    [31:0]              reg_rdata;
  wire   [3:0]               irq_raw;
  reg                        cpu_irq;
  reg    [2:0]               cpu_irq_level;
  wire   [3:0]               src_enabled;

  ////////////////////////////////////////////////////////////////////////////
  // raw request lines index: 0 = src14, 1 = src15, 2 = src30, 3 = src31
  reg  [2:0]  lvl_src31_r;
  reg  [2:0]  lvl_src30_r;
  reg  [2:0]  lvl_src15_r;
  reg  [2:0]  lvl_src14_r;
  reg  [2:0]  mask_r;
  wire [3:0]  pend_sync;
  wire        arb_req;
  wire [2:0]  arb_best;
  wire [31:0] level7_word;
  wire [31:0] mask_word;
  wire [31:0] pend_word;
  reg  [31:0] rdata_nxt;

  function hit;
    input [`ILM_ADDR_W-1:0] a;
    input [`ILM_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request lines come from other blocks' domains in general, so resync
  ilm_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (irq_raw),
    .sync_out (pend_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lvl_src31_r <= `ILM_RST_LEVEL;
      lvl_src30_r <= `ILM_RST_LEVEL;
      lvl_src15_r <= `ILM_RST_LEVEL;
      lvl_src14_r <= `ILM_RST_LEVEL;
      mask_r      <= `ILM_RST_MASK;
    end else if (reg_wr) begin
      if (hit(reg_addr, `ILM_OFF_LEVEL7)) begin
        lvl_src31_r <= reg_wdata[`ILM_POS_SRC31 +: `ILM_LVL_W];
        lvl_src30_r <= reg_wdata[`ILM_POS_SRC30 +: `ILM_LVL_W];
        lvl_src15_r <= reg_wdata[`ILM_POS_SRC15 +: `ILM_LVL_W];
        lvl_src14_r <= reg_wdata[`ILM_POS_SRC14 +: `ILM_LVL_W];
      end
      if (hit(reg_addr, `ILM_OFF_MASK)) begin
        mask_r <= reg_wdata[`ILM_POS_MASK +: `ILM_LVL_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reserved bits read zero
  assign level7_word = {5'h00, lvl_src31_r, 5'h00, lvl_src30_r,
                        5'h00, lvl_src15_r, 5'h00, lvl_src14_r};
  assign mask_word   = {29'h0000000, mask_r};
  // pending shows raw lines only; sources outside this block read zero
  assign pend_word   = {pend_sync[3], pend_sync[2], 14'h0000,
                        pend_sync[1], pend_sync[0], 14'h0000};

  always @* begin
    rdata_nxt = 32'h00000000;
    if (hit(reg_addr, `ILM_OFF_LEVEL7)) begin
      rdata_nxt = level7_word;
    end else if (hit(reg_addr, `ILM_OFF_MASK)) begin
      rdata_nxt = mask_word;
    end else if (hit(reg_addr, `ILM_OFF_PENDING)) begin
      rdata_nxt = pend_word;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level zero and mask seven fall out of the strict compare naturally
  ilm_arbiter #(
    .N (4)
  ) u_arb (
    .pend   (pend_sync),
    .levels ({lvl_src31_r, lvl_src30_r, lvl_src15_r, lvl_src14_r}),
    .mask   (mask_r),
    .req    (arb_req),
    .best   (arb_best)
  );

  // registered so the core sees a glitch-free request
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_irq       <= 1'b0;
      cpu_irq_level <= 3'h0;
    end else begin
      cpu_irq       <= arb_req;
      cpu_irq_level <= arb_best;
    end
  end

  assign src_enabled = {(lvl_src31_r != 3'h0), (lvl_src30_r != 3'h0),
                        (lvl_src15_r != 3'h0), (lvl_src14_r != 3'h0)};

endmodule

// ---- verif/ilm_properties.sv ----
// port checker for the level and mask block
`timescale 1ns/1ps
module ilm_properties (
  input wire        core_clk,
  input wire        nrst,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [3:0]  irq_raw,
  input wire        cpu_irq,
  input wire [2:0]  cpu_irq_level,
  input wire [3:0]  src_enabled
);
  // shadow of the mask, since the checker cannot see inside
  reg [2:0] mask_r;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) mask_r <= 3'h0;
    else if (reg_wr && reg_addr == 16'hF640) mask_r <= reg_wdata[2:0];
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // output lags a mask write by one edge
  sequence s_hold;
    mask_r == $past(mask_r, 3);
  endsequence
  sequence s_live;
    (irq_raw[0] && src_enabled[0] && mask_r == 3'h0)[*5];
  endsequence
  ////////////////////////////////////////////////////////////////////
  idle_level_a: assert property (!cpu_irq |-> cpu_irq_level == 3'h0)
    else $error("level without request");
  off_quiet_a: assert property ((src_enabled == 4'h0)[*5] |-> !cpu_irq)
    else $error("request with all sources off");
  mask_pass_a: assert property (cpu_irq ##0 s_hold |-> cpu_irq_level > mask_r)
    else $error("request not above mask");
  mask_all_a: assert property (mask_r == 3'h7 ##0 s_hold |-> !cpu_irq)
    else $error("request under full mask");
  open_mask_a: assert property (s_live |-> cpu_irq)
    else $error("open mask lost a request");
  mask_rsvd_a: assert property (reg_rd && reg_addr == 16'hF640 |=> reg_rdata[31:3] == 0)
    else $error("mask upper bits set");
  level_rsvd_a: assert property (reg_rd && reg_addr == 16'hF62C |=>
    (reg_rdata & 32'hF8F8F8F8) == 0) else $error("level reserved bits set");
  src_map_a: assert property (reg_wr && reg_addr == 16'hF62C |=>
    src_enabled == {|$past(reg_wdata[26:24]), |$past(reg_wdata[18:16]),
    |$past(reg_wdata[10:8]), |$past(reg_wdata[2:0])}) else $error("level map wrong");
endmodule

// ---- verif/ilm_core_model.sv ----
// core side: takes the request level each cycle
`timescale 1ns/1ps
module ilm_core_model (
  input wire        core_clk,
  input wire        nrst,
  input wire        cpu_irq,
  input wire [2:0]  cpu_irq_level,
  output reg [2:0]  seen_level
);
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) seen_level <= 3'h0;
    else seen_level <= cpu_irq ? cpu_irq_level : 3'h0;
  end
endmodule

// ---- verif/ilm_tb_top.sv ----
// testbench for the level and mask block
`timescale 1ns/1ps
module ilm_tb_top;
  logic        core_clk, nrst, reg_wr, reg_rd, cpu_irq;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  irq_raw, src_enabled;
  logic [2:0]  cpu_irq_level, seen_level;
  int          bad_count, comparisons;
  ilm_top ilm_top_i (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq_raw, .cpu_irq, .cpu_irq_level, .src_enabled);
  ilm_core_model ilm_core_model_i (.core_clk, .nrst, .cpu_irq, .cpu_irq_level,
    .seen_level);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic t_fields;
    rd(16'hF62C, 32'h0);
    rd(16'hF640, 32'h0);
    wr(16'hF62C, 32'hFFFFFFFF);
    rd(16'hF62C, 32'h07070707);
    wr(16'hF640, 32'hFFFFFFFF);
    rd(16'hF640, 32'h7);
    wr(16'hF000, 32'hFFFFFFFF);
    rd(16'hF000, 32'h0);
    $display("fields test done");
  endtask
  task automatic t_levels;
    irq_raw <= 4'h1;
    for (int m = 0; m < 8; m++) begin
      for (int l = 0; l < 8; l++) begin
        wr(16'hF640, m);
        wr(16'hF62C, l);
        repeat (6) @(posedge core_clk);
        #1 chk({cpu_irq, cpu_irq_level}, (l > m) ? 8 + l : 0);
        chk(src_enabled, (l > 0) ? 1 : 0);
      end
    end
    $display("levels test done");
  endtask
  task automatic t_highest;
    wr(16'hF62C, 32'h03060205);
    wr(16'hF640, 32'h0);
    irq_raw <= 4'hF;
    repeat (6) @(posedge core_clk);
    #1 chk(seen_level, 32'h6);
    irq_raw <= 4'hB;
    repeat (6) @(posedge core_clk);
    #1 chk(seen_level, 32'h5);
    wr(16'hF640, 32'h7);
    irq_raw <= 4'hA;
    repeat (4) @(posedge core_clk);
    rd(16'hF680, 32'h80008000);
    $display("highest test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    bad_count++;
    conclude();
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, irq_raw} = '0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_fields();
    t_levels();
    t_highest();
    conclude();
  end
endmodule
bind ilm_top ilm_properties ilm_properties_i (.core_clk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq_raw, .cpu_irq, .cpu_irq_level, .src_enabled);
